// ==== pkg/adcr_pkg.sv ====
// Package: constants and types of the decoder control register bank
package adcr_pkg;

    // Sub-addresses
    localparam logic [7:0] ADDR_REVISION       = 8'h00;
    localparam logic [7:0] ADDR_IDENTITY       = 8'h01;
    localparam logic [7:0] ADDR_CLOCK_TREE     = 8'h05;
    localparam logic [7:0] ADDR_PLL_MULT       = 8'h06;
    localparam logic [7:0] ADDR_PLL_DIV        = 8'h07;
    localparam logic [7:0] ADDR_REQUEST_LINE_POLARITY        = 8'h0c;
    localparam logic [7:0] ADDR_SCLK_POL       = 8'h0d;
    localparam logic [7:0] ADDR_LAST_ERROR     = 8'h0f;
    localparam logic [7:0] ADDR_SOFT_RESET     = 8'h10;
    localparam logic [7:0] ADDR_PLAYBACK       = 8'h13;
    localparam logic [7:0] ADDR_SILENCE        = 8'h14;
    localparam logic [7:0] ADDR_ANC_LOAD       = 8'h16;
    localparam logic [7:0] ADDR_PIN_FUNC       = 8'h18;
    localparam logic [7:0] ADDR_LOCK_STATE     = 8'h40;
    localparam logic [7:0] ADDR_ANC_COUNT_LOW  = 8'h41;
    localparam logic [7:0] ADDR_ANC_COUNT_HIGH = 8'h42;
    localparam logic [7:0] ADDR_VOICE_FIRST    = 8'h40;
    localparam logic [7:0] ADDR_VOICE_LAST     = 8'h51;

    // Hardware reset values
    localparam logic [7:0] HW_CLOCK_TREE = 8'ha1;
    localparam logic [7:0] HW_PLL_MULT   = 8'h0c;
    localparam logic [7:0] HW_PLL_DIV    = 8'h00;
    localparam logic [7:0] HW_REQUEST_LINE_POLARITY    = 8'h00;
    localparam logic [7:0] HW_SCLK_POL   = 8'h04;
    localparam logic [7:0] HW_PLAYBACK   = 8'h01;
    // Software reset values
    localparam logic [7:0] SW_CLOCK_TREE = 8'ha1;
    localparam logic [7:0] SW_PLL_MULT   = 8'h0c;
    localparam logic [7:0] SW_PLL_DIV    = 8'h00;
    localparam logic [7:0] SW_REQUEST_LINE_POLARITY    = 8'h01;
    localparam logic [7:0] SW_SCLK_POL   = 8'h04;
    localparam logic [7:0] SW_PLAYBACK   = 8'h01;

    // Field positions
    localparam int BIT_FRACTION_LOAD = 0;
    localparam int BIT_XTAL_OUTCLK   = 1;
    localparam int BIT_XTAL_CORE     = 2;
    localparam int BIT_VCO_DISABLE   = 3;
    localparam int BIT_SYSCLK_OUTCLK = 4;
    localparam int BIT_OUTCLK_PAD    = 5;
    localparam int BIT_XTAL_OUT_DIS  = 6;
    localparam int BIT_SHARED_PIN    = 7;
    localparam int BIT_POLARITY      = 2;
    localparam int BIT_PLAY          = 0;
    localparam int BIT_MUTE          = 0;

    localparam int ERROR_W     = 6;
    localparam int LOCK_W      = 2;
    localparam int VOICE_DEPTH = 18;
    localparam int VOICE_IDX_W = 5;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] DEVICE_ADDRESS = 7'h43;

    typedef enum logic [3:0] {
        LINK_IDLE, LINK_DEVICE, LINK_DEVICE_ACK, LINK_SUBADDR,
        LINK_SUBADDR_ACK, LINK_WRITE, LINK_WRITE_ACK, LINK_READ,
        LINK_READ_ACK
    } adcr_link_state_type;

    typedef struct packed {
        logic       crystal_to_outclk_divider;
        logic       crystal_to_core_divider;
        logic       vco_disable;
        logic       sysclk_on_outclk;
        logic       outclk_pad_enable;
        logic       crystal_out_disable;
        logic       shared_pin_enable;
        logic [7:0] pll_multiplier;
        logic [7:0] pll_input_divider;
    } adcr_clock_cfg_type;

    typedef struct packed {
        logic request_active_low;
        logic sample_on_falling;
        logic shared_pin_is_request;
        logic play_active;
        logic mute;
        logic keep_output_clock;
        logic fraction_load;
        logic soft_reset_pulse;
        logic anc_fill_pulse;
    } adcr_decoder_ctrl_type;

    typedef struct packed {
        logic               decoding;
        logic               adpcm_mode;
        logic               error_valid;
        logic [ERROR_W-1:0] error_code;
        logic [LOCK_W-1:0]  lock_state;
        logic [15:0]        anc_count;
        logic               anc_fill_done;
        logic               pll_write;
        logic [7:0]         pll_mult;
        logic [7:0]         pll_div;
    } adcr_decoder_status_type;

endpackage : adcr_pkg

// ==== logic/adcr_pin_sync.sv ====
// Two-flop pin synchroniser with edge detection
`timescale 1ns/100ps
module adcr_pin_sync #(
    parameter int WIDTH = 2
) (
    input  logic             mclk,
    input  logic             nrst,
    input  logic             ce,
    input  logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
        logic [WIDTH-1:0] third;
    } adcr_sync_state_type;

    adcr_sync_state_type r;
    adcr_sync_state_type next_r;

    always_comb begin
        next_r        = r;
        next_r.first  = pin;
        next_r.second = r.first;
        next_r.third  = r.second;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r <= '1;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // Only the second and third stages feed logic
    assign level = r.second;
    assign rise  = r.second & ~r.third;
    assign fall  = ~r.second & r.third;
endmodule : adcr_pin_sync

// ==== logic/adcr_regs.sv ====
// Control and status register bank behind the serial control port
//
// Behaviour
// - Read-only revision register at sub-address 0x00.
// - Read-only identity register at 0x01, fixed through both resets.
// - Clock-control bit 0 set loads the PLL fraction; one after boot.
// - Bits 1 and 2 route crystal to output and core dividers; clear at reset.
// - Clock-control bit 3 disables the VCO output; clear at reset.
// - Clock-control bit 4 puts system clock on output clock; clear at reset.
// - Clock-control bit 5 enables output-clock pad; set at reset.
// - Clock-control bit 6 disables the crystal-output pad; clear at reset.
// - Clock-control bit 7 enables the shared pin; one after boot.
// - PLL multiplier and divider are read/write, driven by firmware too.
// - Request polarity bit 2 selects active-high or active-low request.
// - Serial clock polarity bit 2 selects the sampling edge.
// - Six-bit error register holds the most recent error code.
// - Any write to 0x10 soft-resets; registers take software reset values, decoder idles.
// - Play takes effect only while the decoder is decoding.
// - Silence bit 0 mutes the output and keeps output clock running.
// - Non-zero write to load command makes the decoder fill ancillary data.
// - Pin-function bit 2 picks crystal copy or request on shared pin.
// - Two-bit lock state reads at 0x40.
// - 0x40 to 0x51 also form an encoded-data buffer, written always, read in place of status in ADPCM mode.
// - Ancillary bit count reads as low byte 0x41 and high 0x42.
// - Every register sits in an eight-bit byte, accessed eight bits at a time.
// - Sub-address counter increments after every byte read or written.
`timescale 1ns/100ps
module adcr_regs
    import adcr_pkg::*;
#(
    parameter logic [7:0] CHIP_REVISION = 8'h01,
    // Arbitrary identity value
    parameter logic [7:0] CHIP_IDENTITY = 8'h5a,
    parameter logic [6:0] BUS_ADDRESS   = DEVICE_ADDRESS
) (
    input  logic                    mclk,
    input  logic                    nrst,
    input  logic                    ce,
    input  logic                    scl_in,
    input  logic                    sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    input  adcr_decoder_status_type status,
    output adcr_clock_cfg_type      clock_cfg,
    output adcr_decoder_ctrl_type   decoder_ctrl
);

    typedef struct packed {
        adcr_link_state_type          fsm;
        logic [3:0]                   bitcnt;
        logic [7:0]                   shreg;
        logic                         rw;
        logic                         drive;
        logic [7:0]                   ptr;
        logic [7:0]                   clock_tree;
        logic [7:0]                   pll_mult;
        logic [7:0]                   pll_div;
        logic [7:0]                   request_line_polarity;
        logic [7:0]                   sclk_pol;
        logic [ERROR_W-1:0]           last_error;
        logic                         play;
        logic                         mute;
        logic [7:0]                   anc_load;
        logic [7:0]                   pin_func;
        logic [VOICE_DEPTH-1:0][7:0]  voice;
        logic                         fraction_pulse;
        logic                         soft_pulse;
        logic                         anc_pulse;
    } adcr_state_type;

    adcr_state_type r;
    adcr_state_type next_r;

    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic       scl;
    logic       sda;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic       host_write;
    logic       load_read;
    logic       soft_reset;
    logic [7:0] read_data;

    adcr_pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .mclk  (mclk),
        .nrst  (nrst),
        .ce    (ce),
        .pin   ({scl_in, sda_in}),
        .level (pin_level),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    assign scl        = pin_level[1];
    assign sda        = pin_level[0];
    assign scl_rise   = pin_rise[1];
    assign scl_fall   = pin_fall[1];
    assign start_seen = scl & pin_fall[0];
    assign stop_seen  = scl & pin_rise[0];

    function automatic logic in_voice(input logic [7:0] addr);
        in_voice = (addr >= ADDR_VOICE_FIRST) && (addr <= ADDR_VOICE_LAST);
    endfunction : in_voice

    function automatic logic [VOICE_IDX_W-1:0] voice_idx(
        input logic [7:0] addr
    );
        logic [7:0] diff;
        diff      = addr - ADDR_VOICE_FIRST;
        voice_idx = diff[VOICE_IDX_W-1:0];
    endfunction : voice_idx

    // Read multiplexer; unmapped sub-addresses read zero
    always_comb begin
        read_data = 8'h00;
        if (r.ptr == ADDR_REVISION) begin
            read_data = CHIP_REVISION;
        end else if (r.ptr == ADDR_IDENTITY) begin
            read_data = CHIP_IDENTITY;
        end else if (r.ptr == ADDR_CLOCK_TREE) begin
            read_data = r.clock_tree;
        end else if (r.ptr == ADDR_PLL_MULT) begin
            read_data = r.pll_mult;
        end else if (r.ptr == ADDR_PLL_DIV) begin
            read_data = r.pll_div;
        end else if (r.ptr == ADDR_REQUEST_LINE_POLARITY) begin
            read_data = r.request_line_polarity;
        end else if (r.ptr == ADDR_SCLK_POL) begin
            read_data = {5'h00, r.sclk_pol[2:0]};
        end else if (r.ptr == ADDR_LAST_ERROR) begin
            read_data = {2'h0, r.last_error};
        end else if (r.ptr == ADDR_PLAYBACK) begin
            read_data = {7'h00, r.play};
        end else if (r.ptr == ADDR_SILENCE) begin
            read_data = {7'h00, r.mute};
        end else if (r.ptr == ADDR_ANC_LOAD) begin
            read_data = r.anc_load;
        end else if (r.ptr == ADDR_PIN_FUNC) begin
            read_data = {5'h00, r.pin_func[BIT_POLARITY], 2'h0};
        end else if (in_voice(r.ptr) && status.adpcm_mode) begin
            read_data = r.voice[voice_idx(r.ptr)];
        end else if (r.ptr == ADDR_LOCK_STATE) begin
            read_data = {6'h00, status.lock_state};
        end else if (r.ptr == ADDR_ANC_COUNT_LOW) begin
            read_data = status.anc_count[7:0];
        end else if (r.ptr == ADDR_ANC_COUNT_HIGH) begin
            read_data = status.anc_count[15:8];
        end
    end

    always_comb begin
        next_r                = r;
        next_r.fraction_pulse = 1'b0;
        next_r.soft_pulse     = 1'b0;
        next_r.anc_pulse      = 1'b0;
        host_write            = 1'b0;
        load_read             = 1'b0;
        soft_reset            = 1'b0;

        // Serial control port, one byte of eight bits at a time
        if (start_seen) begin
            next_r.fsm    = LINK_DEVICE;
            next_r.bitcnt = 4'h0;
            next_r.drive  = 1'b0;
        end else if (stop_seen) begin
            next_r.fsm   = LINK_IDLE;
            next_r.drive = 1'b0;
        end else begin
            case (r.fsm)
                LINK_DEVICE, LINK_SUBADDR, LINK_WRITE: begin
                    if (scl_rise) begin
                        next_r.shreg  = {r.shreg[6:0], sda};
                        next_r.bitcnt = r.bitcnt + 4'h1;
                    end else if (scl_fall && r.bitcnt == BITS_PER_BYTE) begin
                        next_r.bitcnt = 4'h0;
                        next_r.drive  = 1'b1;
                        if (r.fsm == LINK_DEVICE) begin
                            next_r.rw  = r.shreg[0];
                            next_r.fsm = LINK_DEVICE_ACK;
                            if (r.shreg[7:1] != BUS_ADDRESS) begin
                                next_r.fsm   = LINK_IDLE;
                                next_r.drive = 1'b0;
                            end
                        end else if (r.fsm == LINK_SUBADDR) begin
                            next_r.ptr = r.shreg;
                            next_r.fsm = LINK_SUBADDR_ACK;
                        end else begin
                            host_write = 1'b1;
                            next_r.ptr = r.ptr + 8'h01;
                            next_r.fsm = LINK_WRITE_ACK;
                        end
                    end
                end
                LINK_DEVICE_ACK: begin
                    if (scl_fall) begin
                        if (r.rw) begin
                            load_read = 1'b1;
                        end else begin
                            next_r.drive = 1'b0;
                            next_r.fsm   = LINK_SUBADDR;
                        end
                    end
                end
                LINK_SUBADDR_ACK, LINK_WRITE_ACK: begin
                    if (scl_fall) begin
                        next_r.drive = 1'b0;
                        next_r.fsm   = LINK_WRITE;
                    end
                end
                LINK_READ: begin
                    if (scl_fall) begin
                        if (r.bitcnt == BITS_PER_BYTE) begin
                            next_r.drive  = 1'b0;
                            next_r.bitcnt = 4'h0;
                            next_r.fsm    = LINK_READ_ACK;
                        end else begin
                            next_r.drive  = ~r.shreg[7];
                            next_r.shreg  = {r.shreg[6:0], 1'b0};
                            next_r.bitcnt = r.bitcnt + 4'h1;
                        end
                    end
                end
                LINK_READ_ACK: begin
                    if (scl_rise) begin
                        if (sda) begin
                            next_r.fsm = LINK_IDLE;
                        end else begin
                            next_r.bitcnt = 4'h1;
                        end
                    end else if (scl_fall && r.bitcnt == 4'h1) begin
                        load_read = 1'b1;
                    end
                end
                default: begin
                    next_r.drive = 1'b0;
                end
            endcase
        end

        if (load_read) begin
            next_r.shreg  = {read_data[6:0], 1'b0};
            next_r.drive  = ~read_data[7];
            next_r.bitcnt = 4'h1;
            next_r.ptr    = r.ptr + 8'h01;
            next_r.fsm    = LINK_READ;
        end

        // Decoder finished filling the ancillary buffer
        if (status.anc_fill_done) begin
            next_r.anc_load = 8'h00;
        end
        // Firmware updates of the PLL setting
        if (status.pll_write) begin
            next_r.pll_mult = status.pll_mult;
            next_r.pll_div  = status.pll_div;
        end

        // Host writes; read-only addresses ignore writes
        if (host_write) begin
            if (r.ptr == ADDR_CLOCK_TREE) begin
                next_r.clock_tree = r.shreg;
                next_r.fraction_pulse = r.shreg[BIT_FRACTION_LOAD];
            end else if (r.ptr == ADDR_PLL_MULT) begin
                next_r.pll_mult = r.shreg;
            end else if (r.ptr == ADDR_PLL_DIV) begin
                next_r.pll_div = r.shreg;
            end else if (r.ptr == ADDR_REQUEST_LINE_POLARITY) begin
                next_r.request_line_polarity = r.shreg;
            end else if (r.ptr == ADDR_SCLK_POL) begin
                next_r.sclk_pol = {5'h00, r.shreg[2:0]};
            end else if (r.ptr == ADDR_SOFT_RESET) begin
                soft_reset = 1'b1;
            end else if (r.ptr == ADDR_PLAYBACK) begin
                next_r.play = r.shreg[BIT_PLAY];
            end else if (r.ptr == ADDR_SILENCE) begin
                next_r.mute = r.shreg[BIT_MUTE];
            end else if (r.ptr == ADDR_ANC_LOAD) begin
                next_r.anc_load  = r.shreg;
                next_r.anc_pulse = (r.shreg != 8'h00);
            end else if (r.ptr == ADDR_PIN_FUNC) begin
                next_r.pin_func = r.shreg & 8'h04;
            end else if (in_voice(r.ptr)) begin
                next_r.voice[voice_idx(r.ptr)] = r.shreg;
            end
        end

        // Software reset takes the software reset values
        if (soft_reset) begin
            next_r.soft_pulse = 1'b1;
            next_r.clock_tree = SW_CLOCK_TREE;
            next_r.pll_mult   = SW_PLL_MULT;
            next_r.pll_div    = SW_PLL_DIV;
            next_r.request_line_polarity    = SW_REQUEST_LINE_POLARITY;
            next_r.sclk_pol   = SW_SCLK_POL;
            next_r.last_error = '0;
            next_r.play       = SW_PLAYBACK[0];
            next_r.mute       = 1'b0;
            next_r.anc_load   = 8'h00;
            next_r.pin_func   = 8'h00;
            next_r.voice      = '0;
        end

        // A new error wins over the clear of a soft reset
        if (status.error_valid) begin
            next_r.last_error = status.error_code;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r            <= '0;
            r.fsm        <= LINK_IDLE;
            r.clock_tree <= HW_CLOCK_TREE;
            r.pll_mult   <= HW_PLL_MULT;
            r.pll_div    <= HW_PLL_DIV;
            r.request_line_polarity    <= HW_REQUEST_LINE_POLARITY;
            r.sclk_pol   <= HW_SCLK_POL;
            r.play       <= HW_PLAYBACK[0];
        end else if (ce) begin
            r <= next_r;
        end
    end

    // Open-drain data line: enable high while pulling low
    assign sda_out = 1'b0;
    assign sda_oe  = r.drive;

    always_comb begin
        clock_cfg.crystal_to_outclk_divider = r.clock_tree[BIT_XTAL_OUTCLK];
        clock_cfg.crystal_to_core_divider = r.clock_tree[BIT_XTAL_CORE];
        clock_cfg.vco_disable = r.clock_tree[BIT_VCO_DISABLE];
        clock_cfg.sysclk_on_outclk = r.clock_tree[BIT_SYSCLK_OUTCLK];
        clock_cfg.outclk_pad_enable = r.clock_tree[BIT_OUTCLK_PAD];
        clock_cfg.crystal_out_disable = r.clock_tree[BIT_XTAL_OUT_DIS];
        clock_cfg.shared_pin_enable = r.clock_tree[BIT_SHARED_PIN];
        clock_cfg.pll_multiplier = r.pll_mult;
        clock_cfg.pll_input_divider = r.pll_div;
    end

    always_comb begin
        decoder_ctrl.request_active_low = r.request_line_polarity[BIT_POLARITY];
        decoder_ctrl.sample_on_falling = r.sclk_pol[BIT_POLARITY];
        decoder_ctrl.shared_pin_is_request = r.pin_func[BIT_POLARITY];
        decoder_ctrl.play_active = r.play & status.decoding;
        decoder_ctrl.mute = r.mute;
        decoder_ctrl.keep_output_clock = r.mute;
        decoder_ctrl.fraction_load = r.fraction_pulse;
        decoder_ctrl.soft_reset_pulse = r.soft_pulse;
        decoder_ctrl.anc_fill_pulse = r.anc_pulse;
    end
endmodule : adcr_regs

// ==== bench/adcr_regs_sva.sv ====
// Concurrent checks on the ports of the register bank
`timescale 1ns/100ps
module adcr_regs_sva
    import adcr_pkg::*;
(
    input wire logic                    mclk,
    input wire logic                    nrst,
    input wire adcr_decoder_status_type status,
    input wire adcr_clock_cfg_type      clock_cfg,
    input wire adcr_decoder_ctrl_type   decoder_ctrl
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_soft;
        decoder_ctrl.soft_reset_pulse ##1 !decoder_ctrl.soft_reset_pulse;
    endsequence
    chk_play_gate: assert property (decoder_ctrl.play_active |->
        status.decoding) else $error("play outside decode");
    chk_mute_clock: assert property (decoder_ctrl.mute ==
        decoder_ctrl.keep_output_clock) else $error("mute stops clock");
    chk_soft_once: assert property (decoder_ctrl.soft_reset_pulse
        |-> s_soft) else $error("soft reset pulse too long");
    chk_soft_values: assert property (s_soft |->
        clock_cfg.pll_multiplier == 8'h0c && !decoder_ctrl.mute &&
        decoder_ctrl.sample_on_falling) else $error("soft reset values");
    chk_fill_once: assert property (decoder_ctrl.anc_fill_pulse
        |=> !decoder_ctrl.anc_fill_pulse) else $error("fill pulse long");
    chk_pll_fraction_once: assert property (decoder_ctrl.fraction_load
        |=> !decoder_ctrl.fraction_load) else $error("fraction pulse long");
    chk_pll_firmware: assert property (status.pll_write |=>
        clock_cfg.pll_multiplier == $past(status.pll_mult) &&
        clock_cfg.pll_input_divider == $past(status.pll_div))
        else $error("firmware pll write lost");
    chk_reset_cfg: assert property (!$past(nrst) |->
        clock_cfg.outclk_pad_enable && !clock_cfg.vco_disable &&
        !clock_cfg.sysclk_on_outclk) else $error("reset clock config");
endmodule : adcr_regs_sva
bind adcr_regs adcr_regs_sva u_sva (.mclk(mclk), .nrst(nrst),
    .status(status), .clock_cfg(clock_cfg), .decoder_ctrl(decoder_ctrl));

// ==== bench/adcr_host.sv ====
// Host master model on the serial control port
`timescale 1ns/100ps
module adcr_host (
    input  wire logic mclk,
    input  wire logic line,
    output logic      scl,
    output logic      sda
);
    logic [7:0] q;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task hp;
        repeat (10) @(negedge mclk);
    endtask : hp
    task start;
        sda = 1'b1; hp; scl = 1'b1; hp; sda = 1'b0; hp; scl = 1'b0;
    endtask : start
    task stop;
        sda = 1'b0; hp; scl = 1'b1; hp; sda = 1'b1; hp;
    endtask : stop
    // Eight bits then the ninth, released high when not acking
    task xfer(input logic [7:0] d, input logic a);
        for (int i = 7; i >= 0; i--) begin
            hp; sda = d[i]; hp; scl = 1'b1; hp; q[i] = line; scl = 1'b0;
        end
        hp; sda = a; hp; scl = 1'b1; hp; scl = 1'b0;
    endtask : xfer
endmodule : adcr_host

// ==== bench/test_audio_decoder_ctrl_regs.sv ====
// Self-checking bench of the decoder control register bank
`timescale 1ns/100ps
module test_audio_decoder_ctrl_regs
    import adcr_pkg::*;
;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
    logic                    mclk = 1'b0;
    logic                    nrst = 1'b0;
    logic                    sda_oe, sda_out, scl, sda;
    adcr_decoder_status_type status = '0;
    adcr_clock_cfg_type      cfg;
    adcr_decoder_ctrl_type   ctl;
    logic [7:0]              expq[$];
    logic [7:0]              e, v;
    int                      error_cnt = 0;
    int                      num_checks = 0;
    event                    got;
    int                      pulses = 0;
    wire                     line = sda_oe ? (sda & sda_out) : sda;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
    always #4 mclk = ~mclk;
    always @(negedge mclk) begin
        pulses = pulses + int'(ctl.fraction_load)
            + int'(ctl.soft_reset_pulse) + int'(ctl.anc_fill_pulse);
    end
    adcr_host host (.mclk(mclk), .line(line), .scl(scl), .sda(sda));
    adcr_regs #(.CHIP_IDENTITY(ID)) DUT (.mclk(mclk), .nrst(nrst), .ce(1'b1),
        .scl_in(scl), .sda_in(line), .sda_out(sda_out), .sda_oe(sda_oe),
        .status(status), .clock_cfg(cfg), .decoder_ctrl(ctl));
    always @(got) begin
        e = expq.pop_front();
        `CHK(host.q, e)
    end
    task hdr(input logic [7:0] a);
        host.start; host.xfer(8'h86, 1'b1); host.xfer(a, 1'b1);
    endtask : hdr
    task wr(input logic [7:0] a, input logic [7:0] d);
        hdr(a); host.xfer(d, 1'b1); host.stop;
    endtask : wr
    task rd(input logic [7:0] a, input int n);
        hdr(a); host.start; host.xfer(8'h87, 1'b1);
        for (int i = 1; i <= n; i++) begin
            host.xfer(8'hff, i == n); -> got;
        end
        host.stop;
    endtask : rd
    task results;
        if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    initial begin
        #600000;
        error_cnt++;
        results;
    end
    initial begin
        v = 8'($urandom(32'h5d250ea9));
        repeat (5) @(negedge mclk);
        nrst = 1'b1;
        `CHK({cfg.outclk_pad_enable, cfg.crystal_out_disable}, 2'b10)
        `CHK({cfg.pll_multiplier, cfg.pll_input_divider}, 16'h0c00)
        `CHK({ctl.request_active_low, ctl.sample_on_falling}, 2'b01)
        repeat (3) @(negedge mclk);
        expq = '{8'h01, ID};
        rd(8'h00, 2);
        v = 8'($urandom);
        wr(8'h05, v | 8'h01);
        `CHK({cfg.shared_pin_enable, cfg.crystal_out_disable,
            cfg.outclk_pad_enable, cfg.sysclk_on_outclk, cfg.vco_disable,
            cfg.crystal_to_core_divider, cfg.crystal_to_outclk_divider},
            v[7:1])
        wr(8'h06, ~v);
        wr(8'h07, v);
        wr(8'h0c, 8'h05);
        wr(8'h0d, v);
        `CHK({ctl.request_active_low, ctl.sample_on_falling}, {1'b1, v[2]})
        expq = '{~v, v, 8'h05, v & 8'h07};
        rd(8'h06, 2);
        rd(8'h0c, 2);
        wr(8'h14, 8'h01);
        wr(8'h18, 8'h04);
        wr(8'h16, 8'h02);
        `CHK({ctl.mute, ctl.keep_output_clock, ctl.shared_pin_is_request,
            ctl.play_active}, 4'b1110)
        status = '{decoding: 1'b1, error_valid: 1'b1, error_code: 6'h2a,
            lock_state: 2'b01, anc_count: 16'h1234, anc_fill_done: 1'b1,
            pll_write: 1'b1, pll_mult: v, pll_div: ~v, default: 1'b0};
        @(negedge mclk);
        status.error_valid = 1'b0;
        status.anc_fill_done = 1'b0;
        status.pll_write = 1'b0;
        @(negedge mclk);
        `CHK({ctl.play_active, cfg.pll_multiplier}, {1'b1, v})
        expq = '{8'h2a, 8'h01, 8'h34, 8'h12, 8'h00};
        rd(8'h0f, 1);
        rd(8'h40, 3);
        rd(8'h16, 1);
        status.adpcm_mode = 1'b1;
        wr(8'h40, v);
        wr(8'h41, ~v);
        expq = '{v, ~v};
        rd(8'h40, 2);
        wr(8'h10, 8'h00);
        expq = '{ID, 8'h01, 8'h04, 8'h00};
        rd(8'h01, 1);
        rd(8'h0c, 2);
        rd(8'h0f, 1);
        `CHK({ctl.mute, cfg.pll_multiplier}, 9'h00c)
        `CHK(pulses, 3)
        results;
    end
endmodule : test_audio_decoder_ctrl_regs
